// ---- src/spi_port_defines.svh ----
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH
// rate codes (sck_rate_select)
`define RATE_DIV4 3'b100
`define RATE_DIV8 3'b000
`define RATE_DIV16 3'b001
`define RATE_DIV32 3'b110
`define RATE_DIV64 3'b010
`define RATE_DIV128 3'b011
// reset values
`define CTRL_RESET 1'b0
`define DATA_RESET 8'h00
// bits per byte
`define BYTE_BITS 4'h8
// receive fifo depth
`define RX_DEPTH 4
`endif

// ---- src/spi_port_pkg.sv ----
`default_nettype none
package spi_port_pkg;
   // link state
   typedef enum logic [1:0] {
      IDLE = 2'b00,
      SHIFT = 2'b01,
      DONE = 2'b11
   } link_state_t;
endpackage : spi_port_pkg
`default_nettype wire

// ---- src/byte_fifo.sv ----
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];  // storage
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;  // occupancy
   logic push;
   logic pop;
   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   // write side
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end
   // pointers and count
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : byte_fifo
`default_nettype wire

// ---- src/spi_master_slave_port.sv ----
`include "spi_port_defines.svh"
`default_nettype none
module spi_master_slave_port (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ctrlWrite,  // write pulse to spi_control_reg
   input wire logic [2:0] wrRate,
   input wire logic wrPolarity,
   input wire logic wrPhase,
   input wire logic wrMaster,
   input wire logic wrEnable,
   input wire logic wrIrqEnable,
   input wire logic statusWrite,  // write pulse to spi_ctrl_status_reg
   input wire logic wrSoftSelect,
   input wire logic wrSelectLevel,
   input wire logic statusRead,  // read pulse of spi_ctrl_status_reg
   input wire logic dataWrite,  // write pulse to spi_data_reg
   input wire logic [7:0] wrData,
   input wire logic dataRead,  // read pulse of spi_data_reg
   input wire logic cpuMask,  // interrupt mask of condition_code_reg
   input wire logic sckIn,
   input wire logic mosiIn,
   input wire logic misoIn,
   input wire logic selectPinN,
   output logic sckOut,
   output logic sckOe,
   output logic mosiOut,
   output logic mosiOe,
   output logic misoOut,
   output logic misoOe,
   output logic [7:0] rdData,
   output logic masterSelect,
   output logic portEnable,
   output logic transferDone,
   output logic masterFault,
   output logic overrun,
   output logic writeCollision,
   output logic irqReq,
   output logic busy
);
   import spi_port_pkg::*;
   logic rstA, rst;  // reset release chain
   logic [2:0] rateSel;
   logic polarity, phase, softSelect, selectLevel, irqEnable;
   logic [7:0] shiftReg;
   logic [3:0] bitCount;
   logic [6:0] divCount;
   logic sckLevel;  // master sck before polarity
   logic sckPrev;
   logic statusSeen;  // done-flag sequence armed
   logic faultArmed;  // fault-clear sequence armed
   logic dataLoaded;
   link_state_t state;
   logic selectInt, sampleBit, rxValid, rxReady, rxOutValid, rxPop;
   logic [7:0] rxOut;
   logic byteEnd, writeOk, sckEdge, leadEdge, selfEdge, outStep;

   // divider terminal count (half-period in mclk cycles minus one) for a rate code
   function automatic logic [6:0] half_div(input logic [2:0] code);
      case (code)
         `RATE_DIV4: half_div = 7'h01;
         `RATE_DIV8: half_div = 7'h03;
         `RATE_DIV16: half_div = 7'h07;
         `RATE_DIV32: half_div = 7'h0f;
         `RATE_DIV64: half_div = 7'h1f;
         `RATE_DIV128: half_div = 7'h3f;
         default: half_div = 7'h03;
      endcase
   endfunction : half_div

   // reset synchroniser
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rstA <= 1'b0;
         rst <= 1'b0;
      end else begin
         rstA <= 1'b1;
         rst <= rstA;
      end
   end

   // internal select level
   assign selectInt = softSelect ? selectLevel : selectPinN;
   // sck edges: master from divider, slave from pin
   assign selfEdge = (state == SHIFT) && (divCount == half_div(rateSel));
   assign sckEdge = masterSelect ? selfEdge : (sckIn != sckPrev);
   // leading edge of a pair is capture when phase is 0
   assign leadEdge = masterSelect ? !sckLevel : ((sckIn ^ polarity) == 1'b1);
   assign sampleBit = (leadEdge ^ phase);
   assign byteEnd = (state == SHIFT) && sckEdge && !sampleBit && (bitCount == `BYTE_BITS);
   assign writeOk = dataWrite && !(transferDone && !statusSeen);
   assign outStep = !(state != IDLE && bitCount != 4'h0) || (sckEdge && !sampleBit);

   // configuration registers
   always_ff @(posedge mclk or negedge rst) begin
      if (!rst) begin
         rateSel <= 3'h0;
         polarity <= `CTRL_RESET;
         phase <= `CTRL_RESET;
         irqEnable <= `CTRL_RESET;
         softSelect <= `CTRL_RESET;
         selectLevel <= `CTRL_RESET;
      end else begin
         if (ctrlWrite) begin
            rateSel <= wrRate;
            polarity <= wrPolarity;
            phase <= wrPhase;
            irqEnable <= wrIrqEnable;
         end
         if (statusWrite) begin
            softSelect <= wrSoftSelect;
            selectLevel <= wrSelectLevel;
         end
      end
   end

   // master select, enable and fault
   always_ff @(posedge mclk or negedge rst) begin
      if (!rst) begin
         masterSelect <= 1'b0;
         portEnable <= 1'b0;
         masterFault <= 1'b0;
         faultArmed <= 1'b0;
      end else if (masterSelect && !selectInt) begin
         masterFault <= 1'b1;
         masterSelect <= 1'b0;
         portEnable <= 1'b0;
         faultArmed <= 1'b0;
      end else begin
         if (statusRead && masterFault) begin
            faultArmed <= 1'b1;
         end
         if (ctrlWrite) begin
            if (!masterFault || faultArmed) begin
               masterSelect <= wrMaster;
               portEnable <= wrEnable;
            end else begin
               masterSelect <= masterSelect & wrMaster;
               portEnable <= portEnable & wrEnable;
            end
            if (faultArmed) begin
               masterFault <= 1'b0;
               faultArmed <= 1'b0;
            end
         end
      end
   end

   // transfer state and shifting
   always_ff @(posedge mclk or negedge rst) begin
      if (!rst) begin
         state <= IDLE;
         shiftReg <= `DATA_RESET;
         bitCount <= 4'h0;
         divCount <= 7'h00;
         sckLevel <= 1'b0;
         sckPrev <= 1'b0;
         dataLoaded <= 1'b0;
      end else begin
         sckPrev <= sckIn;
         case (state)
            IDLE: begin
               sckLevel <= 1'b0;
               bitCount <= 4'h0;
               divCount <= 7'h00;
               if (writeOk && portEnable) begin
                  shiftReg <= wrData;
                  dataLoaded <= 1'b1;
                  if (masterSelect) begin
                     state <= SHIFT;
                  end
               end
               if (!masterSelect && portEnable && !selectInt && sckIn != sckPrev) begin
                  state <= SHIFT;
                  if (sampleBit) begin
                     shiftReg <= {shiftReg[6:0], mosiIn};
                     bitCount <= 4'h1;
                  end
               end
            end
            SHIFT: begin
               if (masterSelect) begin
                  divCount <= selfEdge ? 7'h00 : divCount + 7'h01;
                  if (selfEdge) begin
                     sckLevel <= !sckLevel;
                  end
               end
               if (!portEnable) begin
                  state <= IDLE;
               end else if (sckEdge && sampleBit) begin
                  shiftReg <= {shiftReg[6:0], masterSelect ? misoIn : mosiIn};
                  bitCount <= bitCount + 4'h1;
                  state <= (phase && bitCount == `BYTE_BITS - 4'h1) ? DONE : SHIFT;
               end else if (byteEnd) begin
                  state <= DONE;
               end
            end
            DONE: begin
               state <= IDLE;
               dataLoaded <= 1'b0;
            end
            default: state <= IDLE;
         endcase
      end
   end

   // flags, set wins over clear
   always_ff @(posedge mclk or negedge rst) begin
      if (!rst) begin
         transferDone <= 1'b0;
         overrun <= 1'b0;
         writeCollision <= 1'b0;
         statusSeen <= 1'b0;
      end else begin
         if (statusRead || statusWrite) begin
            statusSeen <= transferDone || statusSeen;
         end
         if (state == DONE) begin
            transferDone <= 1'b1;
            if (transferDone) begin
               overrun <= 1'b1;
            end
         end else if (statusSeen && (dataRead || (dataWrite && !masterSelect))) begin
            transferDone <= 1'b0;
            statusSeen <= 1'b0;
         end
         if (statusRead && state != DONE) begin
            overrun <= 1'b0;
         end
         if (dataWrite && state == SHIFT) begin
            writeCollision <= 1'b1;
         end else if (statusRead) begin
            writeCollision <= 1'b0;
         end
      end
   end

   // receive buffer takes a byte only while the done flag is clear
   assign rxValid = (state == DONE) && !transferDone;
   assign rxPop = dataRead && rxOutValid;

   byte_fifo #(.WIDTH(8), .DEPTH(`RX_DEPTH)) rxFifo (
      .clk(mclk),
      .rstN(rst),
      .inValid(rxValid),
      .inReady(rxReady),
      .inData(shiftReg),
      .outValid(rxOutValid),
      .outReady(dataRead),
      .outData(rxOut)
   );

   // registered outputs
   always_ff @(posedge mclk or negedge rst) begin
      if (!rst) begin
         rdData <= `DATA_RESET;
         sckOut <= 1'b0;
         sckOe <= 1'b0;
         mosiOut <= 1'b0;
         mosiOe <= 1'b0;
         misoOut <= 1'b0;
         misoOe <= 1'b0;
         irqReq <= 1'b0;
         busy <= 1'b0;
      end else begin
         if (rxPop) begin
            rdData <= rxOut;
         end
         sckOut <= sckLevel ^ polarity;
         sckOe <= portEnable && masterSelect;
         mosiOut <= outStep ? shiftReg[7] : mosiOut;
         mosiOe <= portEnable && masterSelect;
         misoOut <= outStep ? shiftReg[7] : misoOut;
         misoOe <= portEnable && !masterSelect && !selectInt;
         irqReq <= irqEnable && !cpuMask && (transferDone || masterFault || overrun);
         busy <= (state != IDLE) || !rxReady;
      end
   end

   a_fault_drop: assert property (@(posedge mclk) disable iff (!rst)
      masterSelect && !selectInt |=> masterFault && !portEnable && !masterSelect)
      else $error("fault did not drop master");
   a_done_set: assert property (@(posedge mclk) disable iff (!rst)
      state == DONE |=> transferDone)
      else $error("done flag missing");
   a_overrun_set: assert property (@(posedge mclk) disable iff (!rst)
      state == DONE && transferDone |=> overrun)
      else $error("overrun missing");
   a_collision_set: assert property (@(posedge mclk) disable iff (!rst)
      dataWrite && state == SHIFT |=> writeCollision)
      else $error("collision missing");
   a_irq_gate: assert property (@(posedge mclk) disable iff (!rst)
      irqReq |-> $past(irqEnable) && !$past(cpuMask))
      else $error("irq without enable");
   a_ovr_clear: assert property (@(posedge mclk) disable iff (!rst)
      statusRead && state != DONE |=> !overrun)
      else $error("overrun not cleared");
   a_write_block: assert property (@(posedge mclk) disable iff (!rst)
      transferDone && !statusSeen && state == IDLE |=> !dataLoaded || $past(dataLoaded))
      else $error("blocked write loaded");
   a_fault_hold: assert property (@(posedge mclk) disable iff (!rst)
      masterFault && !faultArmed && !masterSelect ##1 masterFault |-> !masterSelect)
      else $error("master set under fault");
   c_byte: cover property (@(posedge mclk) disable iff (!rst) state == DONE);
   c_fault: cover property (@(posedge mclk) disable iff (!rst) $rose(masterFault));
   c_overrun: cover property (@(posedge mclk) disable iff (!rst) $rose(overrun));
endmodule : spi_master_slave_port
`default_nettype wire

// ---- test/spi_far_slave.sv ----
`default_nettype none
// external slave model: shifts on the master's sck, loads frames and times sck edges on mclk
module spi_far_slave (
   input wire logic mclk,
   input wire logic sck,
   input wire logic mosi,
   input wire logic pol,
   input wire logic pha,
   input wire logic start,
   input wire logic [7:0] txByte,
   output logic miso,
   output logic [7:0] rxByte,
   output logic [7:0] gap
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh; // bits still to send
   logic [7:0] cnt; // cycles since last sck edge
   logic [4:0] edges; // sck edges seen in this frame
   logic sckSeen; // sck at previous mclk edge
   initial begin
      miso = 1'b0;
      rxByte = 8'h00;
      gap = 8'h00;
      cnt = 8'h00;
      sh = 8'h00;
      edges = 5'h10;
      sckSeen = 1'b0;
   end
   // frame load; phase 0 needs the first bit before the first edge
   always @(posedge mclk) begin
      if (start) begin
         edges <= 5'h00;
         sh <= pha ? txByte : {txByte[6:0], 1'b0};
         miso <= pha ? ~txByte[7] : txByte[7];
      end else if (edges == 5'h10) begin
         miso <= ~miso; // no stable value outside a frame
      end
      cnt <= (sck != sckSeen) ? 8'h01 : cnt + 8'h01;
      if (sck != sckSeen) begin
         gap <= cnt; // spacing of the last two sck edges
      end
      sckSeen <= sck;
   end
   // capture on leading edge for phase 0, trailing for phase 1
   always @(sck) begin
      if (edges < 5'h10) begin
         if ((sck != pol) ^ pha) begin
            rxByte <= {rxByte[6:0], mosi};
         end else begin
            miso <= sh[7]; // msb first
            sh <= sh << 1;
         end
         edges <= edges + 5'h01;
      end
   end
endmodule : spi_far_slave
`default_nettype wire

// ---- test/tb_spi_master_slave_port.sv ----
`default_nettype none
module tb_spi_master_slave_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, nrst, wrPolarity, wrPhase, wrMaster, wrEnable, wrIrqEnable, cpuMask;
   logic wrSoftSelect, wrSelectLevel, start, miso;
   logic [2:0] wrRate;
   logic [4:0] pulse; // ctrl write, status write, status read, data write, data read
   logic [7:0] wrData, rdData, slvTx, slvRx, gap, got;
   logic sckPin, mosiPin, selPin, misoOut, misoOe; // external master pins for slave tests
   logic sckOut, sckOe, mosiOut, mosiOe, masterSelect, portEnable;
   logic transferDone, masterFault, overrun, writeCollision, irqReq, busy;
   int fails = 0;
   int checksDone = 0;
   logic [2:0] codes [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3}; // div 4..128
   spi_master_slave_port DUT (.mclk(mclk), .nrst(nrst), .ctrlWrite(pulse[0]),
      .wrRate(wrRate), .wrPolarity(wrPolarity), .wrPhase(wrPhase), .wrMaster(wrMaster),
      .wrEnable(wrEnable), .wrIrqEnable(wrIrqEnable), .statusWrite(pulse[1]),
      .wrSoftSelect(wrSoftSelect), .wrSelectLevel(wrSelectLevel), .statusRead(pulse[2]),
      .dataWrite(pulse[3]), .wrData(wrData), .dataRead(pulse[4]), .cpuMask(cpuMask),
      .sckIn(sckPin), .mosiIn(mosiPin), .misoIn(miso), .selectPinN(selPin), .sckOut(sckOut),
      .sckOe(sckOe), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoOut(misoOut), .misoOe(misoOe),
      .rdData(rdData), .masterSelect(masterSelect), .portEnable(portEnable),
      .transferDone(transferDone), .masterFault(masterFault), .overrun(overrun),
      .writeCollision(writeCollision), .irqReq(irqReq), .busy(busy));
   spi_far_slave far (.mclk(mclk), .sck(sckOut), .mosi(mosiOut), .pol(wrPolarity),
      .pha(wrPhase), .start(start), .txByte(slvTx), .miso(miso), .rxByte(slvRx), .gap(gap));
   // clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chkBit(input string what, input logic exp, input logic got);
      checksDone++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chkBit
   task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checksDone++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chkByte
   // one-cycle strobe on one access line
   task automatic op(input int k);
      @(posedge mclk);
      pulse[k] <= 1'b1;
      @(posedge mclk);
      pulse <= 5'h00;
      start <= 1'b0;
   endtask : op
   task automatic ctrl(input logic [2:0] rate, input logic [4:0] b);
      {wrPolarity, wrPhase, wrMaster, wrEnable, wrIrqEnable} <= b;
      wrRate <= rate;
      op(0);
   endtask : ctrl
   task automatic stat(input logic ss, input logic lvl);
      wrSoftSelect <= ss;
      wrSelectLevel <= lvl;
      op(1);
   endtask : stat
   task automatic send(input logic [7:0] b, input logic go);
      wrData <= b;
      start <= go;
      op(3);
   endtask : send
   task automatic settle();
      @(posedge mclk);
      #1;
   endtask : settle
   // bounded wait for the shifter to finish, flags one cycle later
   task automatic waitIdle();
      int n;
      n = 0;
      repeat (2) @(posedge mclk);
      #1;
      while (busy !== 1'b0 && n < 3000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chkBit("transfer finished", 1'b1, n < 3000);
      repeat (2) @(posedge mclk);
      #1;
   endtask : waitIdle
   // external master for slave tests: phase 1, four cycles per half period
   task automatic xfer(input logic [7:0] mo, output logic [7:0] mi);
      selPin <= 1'b0; // select held low for the whole byte
      for (int b = 7; b >= 0; b--) begin
         repeat (4) @(posedge mclk);
         sckPin <= 1'b1;
         mosiPin <= mo[b];
         repeat (4) @(posedge mclk);
         mi[b] = misoOut;
         sckPin <= 1'b0;
      end
   endtask : xfer
   task automatic conclude();
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // watchdog well beyond the ~4.5k cycles the tests need
   initial begin
      repeat (60000) @(posedge mclk);
      fails++;
      $display("mismatch watchdog expected finish seen timeout");
      conclude();
   end
   initial begin
      {nrst, pulse, start, cpuMask, wrRate, wrPolarity, wrPhase} = '0;
      {wrMaster, wrEnable, wrIrqEnable, wrSoftSelect, wrSelectLevel} = '0;
      wrData = 8'h00;
      slvTx = 8'h00;
      {sckPin, mosiPin, selPin} = 3'b001;
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      chkBit("master after reset", 1'b0, masterSelect);
      chkBit("enable after reset", 1'b0, portEnable);
      $display("test reset done");
      stat(1'b1, 1'b1);
      // every mode and rate: port off, then master on, then one byte
      for (int i = 0; i < 6; i++) begin
         ctrl(codes[i], {i[1], i[0], 3'b001});
         ctrl(codes[i], {i[1], i[0], 3'b111});
         cpuMask <= i[0];
         slvTx <= 8'hc3 ^ 8'(i * 17);
         settle();
         chkBit("master", 1'b1, masterSelect);
         chkBit("sck driven", 1'b1, sckOe);
         chkBit("mosi driven", 1'b1, mosiOe);
         send(8'(8'h5a + i), 1'b1);
         waitIdle();
         chkByte("mosi byte", 8'(8'h5a + i), slvRx);
         chkByte("sck half period", 8'h02 << i, gap);
         chkBit("sck idle", i[1], sckOut);
         chkBit("done", 1'b1, transferDone);
         chkBit("irq", ~i[0], irqReq);
         op(2);
         op(4);
         settle();
         chkByte("received byte", 8'hc3 ^ 8'(i * 17), rdData);
         chkBit("done cleared", 1'b0, transferDone);
      end
      $display("test modes and rates done");
      cpuMask <= 1'b0;
      slvTx <= 8'h81;
      send(8'ha5, 1'b1);
      repeat (6) @(posedge mclk);
      send(8'h3c, 1'b0);
      settle();
      chkBit("collision", 1'b1, writeCollision);
      chkBit("collision irq", 1'b0, irqReq);
      waitIdle();
      chkByte("byte kept on collision", 8'ha5, slvRx);
      $display("test collision done");
      send(8'h77, 1'b0);
      settle();
      chkBit("write while done", 1'b0, busy);
      op(2);
      slvTx <= 8'h42;
      send(8'h99, 1'b1);
      waitIdle();
      chkBit("overrun", 1'b1, overrun);
      chkByte("second byte sent", 8'h99, slvRx);
      op(4);
      settle();
      chkByte("first byte kept", 8'h81, rdData);
      op(2);
      settle();
      chkBit("overrun cleared", 1'b0, overrun);
      $display("test overrun done");
      stat(1'b1, 1'b0);
      repeat (2) settle();
      chkBit("fault", 1'b1, masterFault);
      chkBit("fault irq", 1'b1, irqReq);
      chkBit("enable dropped", 1'b0, portEnable);
      chkBit("master dropped", 1'b0, masterSelect);
      stat(1'b1, 1'b1);
      ctrl(3'h4, 5'b00111);
      settle();
      chkBit("master refused", 1'b0, masterSelect);
      op(2);
      ctrl(3'h4, 5'b00111);
      settle();
      chkBit("fault cleared", 1'b0, masterFault);
      chkBit("master restored", 1'b1, masterSelect);
      $display("test mode fault done");
      // slave mode: external master clocks one byte in phase 1
      ctrl(3'h4, 5'b01011);
      stat(1'b0, 1'b0);
      send(8'hb4, 1'b0);
      xfer(8'h6e, got);
      repeat (3) settle();
      chkBit("miso driven", 1'b1, misoOe);
      chkByte("miso byte", 8'hb4, got);
      chkBit("slave done", 1'b1, transferDone);
      selPin <= 1'b1;
      op(2);
      send(8'h11, 1'b0);
      settle();
      chkBit("done cleared by write", 1'b0, transferDone);
      chkBit("miso released", 1'b0, misoOe);
      op(4);
      settle();
      chkByte("slave received byte", 8'h6e, rdData);
      $display("test slave done");
      conclude();
   end
endmodule : tb_spi_master_slave_port
`default_nettype wire
